// ==== tb/pps_port_status_monitor.sv ====
// Purpose: Concurrent checks on the port status register read path
// Assumes: Sees only the ports of pps_port_status
// Notes:   Read data is checked the cycle after the read strobe
`timescale 1ns/1ps
module pps_port_status_monitor (
  input wire        mclk,
  input wire        reset_n,
  input wire [4:0]  reg_addr,
  input wire        reg_rd,
  input wire [15:0] reg_rdata,
  input wire        link_up,
  input wire        full_duplex,
  input wire        speed_100,
  input wire        mode_100tx,
  input wire        an_complete,
  input wire        page_received,
  input wire        cipher_locked,
  input wire        symbol_error,
  input wire        mlt3_error,
  input wire        low_voltage,
  input wire        int_n
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  // Read strobe aimed at the status word
  wire rd_st = reg_rd && reg_addr == 5'h14;
  a_link_live: assert property (rd_st |=> reg_rdata[13] == $past(link_up)) else $error("link bit stale");
  a_duplex_speed: assert property (rd_st |=> reg_rdata[12] == $past(full_duplex) &&
    reg_rdata[11] == $past(speed_100)) else $error("duplex or speed wrong");
  a_an_done: assert property (rd_st |=> reg_rdata[9] == $past(an_complete)) else $error("an bit wrong");
  a_page_rx: assert property (rd_st |=> reg_rdata[8] == $past(page_received)) else $error("page bit wrong");
  a_cipher_lock: assert property (rd_st |=> reg_rdata[6] == ($past(mode_100tx) && $past(cipher_locked)))
    else $error("lock bit wrong");
  a_sym_set: assert property (rd_st && $past(symbol_error) |=> reg_rdata[5])
    else $error("symbol flag missing");
  a_mlt3_set: assert property (rd_st && $past(mlt3_error) |=> reg_rdata[4])
    else $error("mlt3 flag missing");
  a_volt_set: assert property (rd_st && $past(low_voltage) |=> reg_rdata[2])
    else $error("voltage flag missing");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
  c_status_read: cover property (rd_st);
  c_volt_read: cover property (rd_st && low_voltage);
  c_int_low: cover property ($fell(int_n));
endmodule // pps_port_status_monitor
bind pps_port_status pps_port_status_monitor u_mon (.mclk, .reset_n, .reg_addr, .reg_rd, .reg_rdata, .link_up,
  .full_duplex, .speed_100, .mode_100tx, .an_complete, .page_received, .cipher_locked, .symbol_error,
  .mlt3_error, .low_voltage, .int_n);

// ==== tb/pps_station.sv ====
// Purpose: Management station model issuing register reads and writes
// Assumes: One-cycle strobes taken on the rising edge
// Notes:   Idle write data and address are inverted so stale values never look valid
`timescale 1ns/1ps
module pps_station (
  input  wire        mclk,
  input  wire [15:0] reg_rdata,
  output reg  [4:0]  reg_addr,
  output reg         reg_rd,
  output reg         reg_wr,
  output reg  [15:0] reg_wdata
);
  initial begin
    reg_addr = 5'h00; reg_rd = 1'b0; reg_wr = 1'b0; reg_wdata = 16'h0000;
  end
  // Write one word; callers keep reserved positions zero
  task wr(input [4:0] a, input [15:0] w); begin
    @(posedge mclk); #1; reg_addr = a; reg_wdata = w; reg_wr = 1'b1;
    @(posedge mclk); #1; reg_wr = 1'b0; reg_wdata = ~reg_wdata; reg_addr = ~reg_addr;
  end endtask
  // Read one word; data is taken once the strobe edge has landed
  task rd(input [4:0] a, output [15:0] d); begin
    @(posedge mclk); #1; reg_addr = a; reg_rd = 1'b1;
    @(posedge mclk); #1; reg_rd = 1'b0; reg_addr = ~reg_addr; d = reg_rdata;
  end endtask
endmodule // pps_station

// ==== tb/tb_pps_port_status.sv ====
// Purpose: Self-checking bench for the port status register block
// Assumes: Station model drives the register strobes
// Notes:   Reserved positions of port status reads are masked before comparing
`timescale 1ns/1ps
module tb_pps_port_status;
  reg mclk = 1'b0, reset_n = 1'b0, an_enable = 1'b0, int_event = 1'b0;
  reg link_up = 1'b0, full_duplex = 1'b0, speed_100 = 1'b0, mode_100tx = 1'b0, an_complete = 1'b0;
  reg page_received = 1'b0, cipher_locked = 1'b0, symbol_error = 1'b0, mlt3_error = 1'b0, low_voltage = 1'b0;
  reg ao_strap = 1'b0, sb_strap = 1'b0, fs_strap = 1'b0;
  wire [4:0] reg_addr;
  wire reg_rd, reg_wr, int_n, ltd, sbp, fbm;
  wire [15:0] reg_wdata, reg_rdata;
  reg [15:0] d, e;
  integer err_count = 0, check_count = 0, i;
  always #5 mclk = ~mclk;
  pps_station sta (.mclk(mclk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata));
  pps_port_status uut (.mclk(mclk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_wr(reg_wr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_up(link_up), .full_duplex(full_duplex),
    .speed_100(speed_100), .mode_100tx(mode_100tx), .an_enable(an_enable), .an_complete(an_complete),
    .page_received(page_received), .cipher_locked(cipher_locked), .symbol_error(symbol_error),
    .mlt3_error(mlt3_error), .low_voltage(low_voltage), .int_event(int_event), .autoneg_off_strap(ao_strap),
    .scrambler_bypass_strap(sb_strap), .fiber_select_strap(fs_strap), .link_test_disable(ltd),
    .scrambler_bypass(sbp), .fiber_mode(fbm), .int_n(int_n));
  // Compare and count
  task chk(input [15:0] g, input [15:0] x); begin
    check_count = check_count + 1;
    if (g !== x) begin
      err_count = err_count + 1;
      $display("BAD %0t got %h expected %h", $time, g, x);
    end
  end endtask
  task cyc(input integer n); begin
    repeat (n) @(posedge mclk);
    #1;
  end endtask
  task close_out; begin
    $display("mismatches %0d comparisons %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  // Hang guard
  initial begin
    #200000;
    err_count = err_count + 1;
    close_out;
  end
  // Main sequence
  initial begin
    for (i = 0; i < 2; i = i + 1) begin
      {an_enable, ao_strap, sb_strap, fs_strap} = i ? 4'b1101 : 4'b0110;
      reset_n = 1'b0; cyc(8); reset_n = 1'b1; cyc(2);
      chk({ltd, sbp, fbm}, i ? 3'b001 : 3'b110);
    end
    sta.wr(5'h13, 16'h0108); sta.rd(5'h13, d); chk(d, 16'h0108);
    chk({ltd, sbp, fbm}, 3'b110);
    for (i = 0; i < 8; i = i + 1) begin
      {link_up, full_duplex, speed_100, an_complete, page_received, mode_100tx, cipher_locked} = i * 7'h13;
      e = {2'b00, link_up, full_duplex, speed_100, 1'b0, an_complete, page_received, 1'b0,
        mode_100tx & cipher_locked, 6'b000000};
      sta.rd(5'h14, d); chk(d & 16'h3B40, e);
    end
    {symbol_error, mlt3_error, low_voltage} = 3'b111; cyc(1); {symbol_error, mlt3_error, low_voltage} = 3'b000;
    cyc(3);
    sta.rd(5'h14, d); chk(d & 16'h0034, 16'h0034);
    sta.rd(5'h14, d); chk(d & 16'h0034, 16'h0000);
    {symbol_error, mlt3_error, low_voltage} = 3'b111; sta.rd(5'h14, d); sta.rd(5'h14, d);
    {symbol_error, mlt3_error, low_voltage} = 3'b000;
    chk(d & 16'h0034, 16'h0034);
    int_event = 1'b1; cyc(1); int_event = 1'b0; cyc(3); chk(int_n, 1'b1);
    sta.wr(5'h11, 16'h0001); cyc(3); chk(int_n, 1'b1);
    sta.wr(5'h11, 16'h0002); int_event = 1'b1; cyc(1); int_event = 1'b0; cyc(3); chk(int_n, 1'b0);
    sta.rd(5'h12, d); chk(d & 16'h8000, 16'h8000);
    sta.rd(5'h12, d); chk(d, 16'h0000);
    sta.wr(5'h11, 16'h0000); cyc(3); chk(int_n, 1'b1);
    sta.wr(5'h11, 16'h0003); cyc(3); chk(int_n, 1'b0);
    sta.rd(5'h11, d); chk(d, 16'h0003);
    sta.wr(5'h11, 16'h0000);
    sta.rd(5'h05, d); chk(d, 16'h0000);
    close_out;
  end
endmodule // tb_pps_port_status

// ==== verilog/pps_latch_flag.v ====
// Purpose: One latching-high status flag with clear on read
// Assumes: Event and read strobe synchronous to mclk
// Notes:   A new event in the read cycle keeps the flag set
`timescale 1ns/1ps
module pps_latch_flag (
  input  wire mclk,
  input  wire reset_n,
  input  wire event_in,
  input  wire read_clear,
  output reg  flag
);
  // Set wins over clear; clear only once condition is gone
  always @(posedge mclk) begin
    if (!reset_n) begin
      flag <= 1'b0;
    end else if (event_in) begin
      flag <= 1'b1;
    end else if (read_clear) begin
      flag <= 1'b0;
    end
  end
endmodule // pps_latch_flag

// ==== verilog/pps_port_status.v ====
// Purpose: Port status register with its neighbours for one transceiver port
// Assumes: Management frame decoder delivers one-cycle read/write strobes
// Notes:   Read data is registered and valid the cycle after the read strobe
`timescale 1ns/1ps
`include "pps_regs.vh"
module pps_port_status #(
  parameter FIBER_CAPABLE = 1'b1
) (
  input  wire        mclk,
  input  wire        reset_n,
  input  wire [4:0]  reg_addr,
  input  wire        reg_rd,
  input  wire        reg_wr,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata,
  input  wire        link_up,
  input  wire        full_duplex,
  input  wire        speed_100,
  input  wire        mode_100tx,
  input  wire        an_enable,
  input  wire        an_complete,
  input  wire        page_received,
  input  wire        cipher_locked,
  input  wire        symbol_error,
  input  wire        mlt3_error,
  input  wire        low_voltage,
  input  wire        int_event,
  input  wire        autoneg_off_strap,
  input  wire        scrambler_bypass_strap,
  input  wire        fiber_select_strap,
  output wire        link_test_disable,
  output wire        scrambler_bypass,
  output wire        fiber_mode,
  output reg         int_n
);
  reg        strap_done;
  reg        link_test_bit;
  reg        scr_bypass_bit;
  reg        fiber_bit;
  reg        interrupt_enable_bit;
  reg        int_test_bit;
  reg        int_pending;
  reg        res7_bit;
  wire       rd_status;
  wire       rd_int_status;
  wire       wr_status;
  wire       wr_cfg;
  wire       wr_int_ctrl;
  wire       int_cause;
  wire       sym_flag;
  wire       mlt3_flag;
  wire       lv_flag;
  wire [15:0] status_word;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  // Exact index match shared by every strobe decode
  function pps_addr_hit (input [4:0] addr, input [4:0] target);
    pps_addr_hit = (addr == target);
  endfunction

  // One-cycle strobes per register, qualified by the index
  assign rd_status     = reg_rd && pps_addr_hit(reg_addr, `PPS_ADDR_PORT_STATUS);
  assign rd_int_status = reg_rd && pps_addr_hit(reg_addr, `PPS_ADDR_INT_STATUS);
  assign wr_status     = reg_wr && pps_addr_hit(reg_addr, `PPS_ADDR_PORT_STATUS);
  assign wr_cfg        = reg_wr && pps_addr_hit(reg_addr, `PPS_ADDR_PORT_CFG);
  assign wr_int_ctrl   = reg_wr && pps_addr_hit(reg_addr, `PPS_ADDR_INT_CTRL);

  // ----------------------------------------
  // Latching-high flags
  // ----------------------------------------
  // Condition still present sets again, so read only clears a gone event
  // Received symbol errors
  pps_latch_flag u_sym (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .event_in   (symbol_error),
    .read_clear (rd_status),
    .flag       (sym_flag)
  );

  // Line-code errors on the receive path
  pps_latch_flag u_mlt3 (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .event_in   (mlt3_error),
    .read_clear (rd_status),
    .flag       (mlt3_flag)
  );

  // Supply low-voltage detector reports
  pps_latch_flag u_lv (
    .mclk       (mclk),
    .reset_n    (reset_n),
    .event_in   (low_voltage),
    .read_clear (rd_status),
    .flag       (lv_flag)
  );

  // ----------------------------------------
  // Status word assembly
  // ----------------------------------------
  // Live levels beside the latched flags, captured at the read edge
  assign status_word = {2'b00,
                        link_up,
                        full_duplex,
                        speed_100,
                        1'b0,
                        an_complete,
                        page_received,
                        res7_bit,
                        mode_100tx & cipher_locked,
                        sym_flag,
                        mlt3_flag,
                        1'b0,
                        lv_flag,
                        2'b00};

  // ----------------------------------------
  // Configuration bits with strap defaults
  // ----------------------------------------
  // Straps caught by clocked load on the first cycle after reset release
  always @(posedge mclk) begin
    if (!reset_n) begin
      strap_done     <= 1'b0;
      link_test_bit  <= 1'b0;
      scr_bypass_bit <= 1'b0;
      fiber_bit      <= 1'b0;
    end else if (!strap_done) begin
      strap_done     <= 1'b1;
      link_test_bit  <= (~an_enable) & autoneg_off_strap;
      scr_bypass_bit <= scrambler_bypass_strap;
      fiber_bit      <= fiber_select_strap;
    end else if (wr_cfg) begin
      link_test_bit  <= reg_wdata[`PPS_CFG_LINK_TEST];
      scr_bypass_bit <= reg_wdata[`PPS_CFG_SCR_BYPASS];
      fiber_bit      <= reg_wdata[`PPS_CFG_FIBER];
    end
  end

  // Config outputs follow the stored bits; fiber needs a capable port
  assign link_test_disable = link_test_bit;
  assign scrambler_bypass  = scr_bypass_bit;
  assign fiber_mode        = fiber_bit & FIBER_CAPABLE;

  // ----------------------------------------
  // Writable reserved bit and interrupt control
  // ----------------------------------------
  // Reserved bit 7 stores what is written; station keeps it zero
  always @(posedge mclk) begin
    if (!reset_n) begin
      res7_bit             <= 1'b0;
      interrupt_enable_bit <= 1'b0;
      int_test_bit         <= 1'b0;
    end else begin
      if (wr_status) begin
        res7_bit <= reg_wdata[`PPS_ST_RES7];
      end
      if (wr_int_ctrl) begin
        interrupt_enable_bit <= reg_wdata[`PPS_IC_ENABLE];
        int_test_bit         <= reg_wdata[`PPS_IC_TEST];
      end
    end
  end

  // ----------------------------------------
  // Interrupt pending and output
  // ----------------------------------------
  // Interrupt source gated by the enable bit
  assign int_cause = interrupt_enable_bit && (int_event || int_test_bit);

  // Pending set only while enabled; set wins over read clear
  always @(posedge mclk) begin
    if (!reset_n) begin
      int_pending <= 1'b0;
      int_n       <= 1'b1;
    end else begin
      if (int_cause) begin
        int_pending <= 1'b1;
      end else if (!interrupt_enable_bit) begin
        int_pending <= 1'b0;
      end else if (rd_int_status) begin
        int_pending <= 1'b0;
      end
      // Output lags pending by one edge
      int_n <= ~(interrupt_enable_bit && (int_pending || int_test_bit));
    end
  end

  // ----------------------------------------
  // Read data mux
  // ----------------------------------------
  // Registered read data; unmapped addresses read zero
  always @(posedge mclk) begin
    if (!reset_n) begin
      reg_rdata <= `PPS_RST_ZERO16;
    end else if (reg_rd) begin
      case (reg_addr)
        `PPS_ADDR_PORT_STATUS: reg_rdata <= status_word;
        `PPS_ADDR_PORT_CFG:    reg_rdata <= {7'h00, link_test_bit, 4'h0, scr_bypass_bit, fiber_bit, 2'b00};
        `PPS_ADDR_INT_CTRL:    reg_rdata <= {14'h0000, interrupt_enable_bit, int_test_bit};
        `PPS_ADDR_INT_STATUS:  reg_rdata <= {int_pending, 15'h0000};
        default:               reg_rdata <= `PPS_RST_ZERO16;
      endcase
    end
  end
endmodule // pps_port_status

// ==== verilog/pps_regs.vh ====
// Purpose: Constants for the port status register block
// Assumes: Management register index space of 32 registers, 16-bit data
// Notes:   Bit positions are within the 16-bit register word
`ifndef PPS_REGS_VH
`define PPS_REGS_VH
// ----------------------------------------
// Register addresses
// ----------------------------------------
`define PPS_ADDR_INT_CTRL    5'h11
`define PPS_ADDR_INT_STATUS  5'h12
`define PPS_ADDR_PORT_CFG    5'h13
`define PPS_ADDR_PORT_STATUS 5'h14
// ----------------------------------------
// Port status bit positions
// ----------------------------------------
`define PPS_ST_LINK      13
`define PPS_ST_DUPLEX    12
`define PPS_ST_SPEED     11
`define PPS_ST_AN_DONE   9
`define PPS_ST_PAGE_RX   8
`define PPS_ST_RES7      7
`define PPS_ST_LOCK      6
`define PPS_ST_SYM_ERR   5
`define PPS_ST_MLT3_ERR  4
`define PPS_ST_LOW_VOLT  2
`define PPS_ST_RES1      1
// ----------------------------------------
// Port configuration bit positions
// ----------------------------------------
`define PPS_CFG_LINK_TEST  8
`define PPS_CFG_SCR_BYPASS 3
`define PPS_CFG_FIBER      2
// ----------------------------------------
// Interrupt control and status bit positions
// ----------------------------------------
`define PPS_IC_ENABLE 1
`define PPS_IC_TEST   0
`define PPS_IS_PEND   15
// ----------------------------------------
// Reset values
// ----------------------------------------
`define PPS_RST_ZERO16 16'h0000
`endif
